// ---- logic/rrx_pkg.sv ----
// Purpose: shared constants for the rotate execution block
// Assumes: AHB-Lite word registers, 12-bit file address space
// Notes: offsets are byte addresses on the register bus
package rrx_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_WREG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_BANK = 8'h10;
  localparam logic [7:0] OFS_IDX_BASE = 8'h14;
  localparam logic [7:0] OFS_FADDR = 8'h18;
  localparam logic [7:0] OFS_FDATA = 8'h1c;
  localparam logic [7:0] OFS_LASTADDR = 8'h20;
  // status field positions
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_NEG = 2;
  localparam int ST_BUSY = 8;
  localparam int ST_BADOP = 9;
  // instruction encoding
  localparam logic [5:0] OPC_RLNC = 6'h11;
  localparam logic [5:0] OPC_RRC = 6'h0c;
  localparam int INS_DEST = 9;
  localparam int INS_ACC = 8;
  // address map
  localparam int FILE_DEPTH = 1024;
  localparam logic [11:0] FILE_LIMIT = 12'h400;
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_ADDR12 = 12'h000;
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // sequencer phases of one instruction cycle
  typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} rrx_phase_type;
endpackage : rrx_pkg

// ---- logic/rrx_rotate_alu.sv ----
// Purpose: combinational byte rotator with flag outputs
// Assumes: one operation selected per call, carry comes from status
// Notes: no state; the sequencer registers the results
`timescale 1ns/100ps
module rrx_rotate_alu (
  input wire logic rot_left_in, // 1 left no carry, 0 right through carry
  input wire logic [7:0] opnd_in, // operand byte
  input wire logic carry_in, // current carry flag
  output logic [7:0] res_out, // rotated byte
  output logic carry_out, // carry after the operation
  output logic neg_out, // result bit 7
  output logic zero_out // result is zero
);
  // both rotations, negative and zero flags taken from the result
  always_comb begin
    if (rot_left_in) begin
      res_out = {opnd_in[6:0], opnd_in[7]};
      carry_out = carry_in;
    end else begin
      res_out = {carry_in, opnd_in[7:1]};
      carry_out = opnd_in[0];
    end
    neg_out = res_out[7];
    zero_out = (res_out == 8'h00);
  end
endmodule : rrx_rotate_alu

// ---- logic/rrx_rotate_exec.sv ----
// Purpose: executes the two byte rotate instructions over a file space
// Assumes: AHB-Lite slave with zero wait states, single word transfers
// Notes: writing the instruction register starts one four-phase cycle
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module rrx_rotate_exec (
  input wire logic MCLK_IN, // 100 MHz clock
  input wire logic RST_IN, // synchronous reset, active high
  input wire logic HSEL_IN, // slave select
  input wire logic [31:0] HADDR_IN, // byte address
  input wire logic [1:0] HTRANS_IN, // transfer type
  input wire logic HWRITE_IN, // 1 write
  input wire logic [2:0] HSIZE_IN, // transfer size, word only
  input wire logic [31:0] HWDATA_IN, // write data
  input wire logic HREADY_IN, // bus ready
  output logic [31:0] HRDATA_OUT, // read data
  output logic HREADYOUT_OUT, // slave ready
  output logic HRESP_OUT, // always OKAY
  output logic BUSY_OUT // instruction in flight
);
  import rrx_pkg::*;

  rrx_phase_type phase_q;
  logic ext_en_q;
  logic [15:0] instr_q;
  logic [7:0] wreg_q;
  logic carry_q, zero_q, neg_q, badop_q;
  logic [3:0] bank_q;
  logic [11:0] idx_base_q, faddr_q, addr_q;
  logic [7:0] opnd_q, res_q;
  logic cout_q, nflag_q, zflag_q;
  logic [7:0] fmem [FILE_DEPTH];
  logic wr_pend_q;
  logic [7:0] wr_ofs_q;
  logic [7:0] alu_res;
  logic alu_c, alu_n, alu_z;
  logic take, is_rl, dest_f, acc_a, bus_wr, idx_mode, start;
  logic [7:0] fld;
  logic [31:0] rd_d;
  logic [11:0] addr_d;

  // instruction field views
  assign fld = instr_q[7:0];
  assign is_rl = (instr_q[15:10] == OPC_RLNC);
  assign dest_f = instr_q[INS_DEST];
  assign acc_a = instr_q[INS_ACC];
  assign idx_mode = ext_en_q && !acc_a && (fld <= IDX_LIMIT);
  assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign bus_wr = wr_pend_q;
  assign start = bus_wr && (wr_ofs_q == OFS_INSTR) && (phase_q == PH_IDLE);

  // address phase capture for the data phase write
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
    end else begin
      wr_pend_q <= take && HWRITE_IN;
      wr_ofs_q <= HADDR_IN[7:0];
    end
  end

  // read mux; a read right after a write to the same word sees the old value
  always_comb begin
    rd_d = RST_WORD;
    case (HADDR_IN[7:0])
      OFS_CTRL: rd_d = {31'h0, ext_en_q};
      OFS_INSTR: rd_d = {16'h0, instr_q};
      OFS_WREG: rd_d = {24'h0, wreg_q};
      OFS_STATUS: rd_d = {22'h0, badop_q, (phase_q != PH_IDLE), 5'h0, neg_q, zero_q, carry_q};
      OFS_BANK: rd_d = {28'h0, bank_q};
      OFS_IDX_BASE: rd_d = {20'h0, idx_base_q};
      OFS_FADDR: rd_d = {20'h0, faddr_q};
      OFS_FDATA: rd_d = (faddr_q < FILE_LIMIT) ? {24'h0, fmem[faddr_q[9:0]]} : RST_WORD;
      OFS_LASTADDR: rd_d = {20'h0, addr_q};
      default: rd_d = RST_WORD; // unmapped reads zero
    endcase
  end

  // registered read data, zero wait states
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      HRDATA_OUT <= RST_WORD;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      if (take && !HWRITE_IN) begin
        HRDATA_OUT <= rd_d;
      end
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
  end

  // software configuration registers, frozen while busy
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ext_en_q <= 1'b0;
      bank_q <= RST_BANK;
      idx_base_q <= RST_ADDR12;
      faddr_q <= RST_ADDR12;
      instr_q <= RST_INSTR;
    end else if (bus_wr && phase_q == PH_IDLE) begin
      case (wr_ofs_q)
        OFS_CTRL: ext_en_q <= HWDATA_IN[0];
        OFS_INSTR: instr_q <= HWDATA_IN[15:0];
        OFS_BANK: bank_q <= HWDATA_IN[3:0];
        OFS_IDX_BASE: idx_base_q <= HWDATA_IN[11:0];
        OFS_FADDR: faddr_q <= HWDATA_IN[11:0];
        default: ;
      endcase
    end
  end

  // four phases per instruction, back to idle after write
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      phase_q <= PH_IDLE;
    end else begin
      case (phase_q)
        PH_IDLE: if (start) phase_q <= PH_DECODE;
        PH_DECODE: phase_q <= PH_READ;
        PH_READ: phase_q <= PH_PROCESS;
        PH_PROCESS: phase_q <= PH_WRITE;
        PH_WRITE: phase_q <= PH_IDLE;
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // operand address resolution
  always_comb begin
    if (idx_mode) begin
      addr_d = idx_base_q + {4'h0, fld};
    end else if (!acc_a) begin
      addr_d = {(fld < ACC_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK, fld};
    end else begin
      addr_d = {bank_q, fld};
    end
  end

  // decode, read and process stages
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      addr_q <= RST_ADDR12;
      opnd_q <= RST_BYTE;
      res_q <= RST_BYTE;
      cout_q <= 1'b0;
      nflag_q <= 1'b0;
      zflag_q <= 1'b0;
    end else begin
      if (phase_q == PH_DECODE) addr_q <= addr_d;
      if (phase_q == PH_READ) opnd_q <= (addr_q < FILE_LIMIT) ? fmem[addr_q[9:0]] : RST_BYTE;
      if (phase_q == PH_PROCESS) begin
        res_q <= alu_res;
        cout_q <= alu_c;
        nflag_q <= alu_n;
        zflag_q <= alu_z;
      end
    end
  end

  rrx_rotate_alu u_alu (
    .rot_left_in(is_rl),
    .opnd_in(opnd_q),
    .carry_in(carry_q),
    .res_out(alu_res),
    .carry_out(alu_c),
    .neg_out(alu_n),
    .zero_out(alu_z)
  );

  // accumulator and flags; an unknown opcode only raises the sticky flag
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      wreg_q <= RST_BYTE;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      neg_q <= 1'b0;
      badop_q <= 1'b0;
    end else begin
      if (bus_wr && phase_q == PH_IDLE && wr_ofs_q == OFS_WREG) wreg_q <= HWDATA_IN[7:0];
      if (bus_wr && phase_q == PH_IDLE && wr_ofs_q == OFS_STATUS) begin
        carry_q <= HWDATA_IN[ST_CARRY];
        zero_q <= HWDATA_IN[ST_ZERO];
        neg_q <= HWDATA_IN[ST_NEG];
        if (HWDATA_IN[ST_BADOP]) badop_q <= 1'b0; // write one to clear
      end
      if (phase_q == PH_WRITE && (is_rl || instr_q[15:10] == OPC_RRC)) begin
        if (!dest_f) wreg_q <= res_q;
        carry_q <= cout_q;
        zero_q <= zflag_q;
        neg_q <= nflag_q;
      end
      if (start && !(HWDATA_IN[15:10] == OPC_RLNC || HWDATA_IN[15:10] == OPC_RRC)) begin
        badop_q <= 1'b1; // set beats a same-cycle clear
      end
    end
  end

  // file storage; addresses past the implemented banks are dropped
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < FILE_DEPTH; i++) fmem[i] <= RST_BYTE;
    end else if (phase_q == PH_WRITE && dest_f && addr_q < FILE_LIMIT &&
                 (is_rl || instr_q[15:10] == OPC_RRC)) begin
      fmem[addr_q[9:0]] <= res_q;
    end else if (bus_wr && phase_q == PH_IDLE && wr_ofs_q == OFS_FDATA && faddr_q < FILE_LIMIT) begin
      fmem[faddr_q[9:0]] <= HWDATA_IN[7:0];
    end
  end

  // busy flag to the pin
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) BUSY_OUT <= 1'b0;
    else BUSY_OUT <= (phase_q != PH_IDLE && phase_q != PH_WRITE) || start;
  end

  AST_RLNC_WRAP: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_PROCESS && is_rl) |=> res_q == {$past(opnd_q[6:0]), $past(opnd_q[7])})
    else $error("left rotate result wrong");
  AST_RRC_CARRY: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_PROCESS && !is_rl) |=> res_q == {$past(carry_q), $past(opnd_q[7:1])} && cout_q == $past(opnd_q[0]))
    else $error("right rotate through carry wrong");
  AST_DEST_W: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_WRITE && !dest_f && (is_rl || instr_q[15:10] == OPC_RRC)) |=> wreg_q == $past(res_q))
    else $error("accumulator not written");
  AST_DEST_F: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_WRITE && dest_f && is_rl && addr_q < FILE_LIMIT) |=> fmem[$past(addr_q[9:0])] == $past(res_q))
    else $error("file register not written");
  AST_ACCESS_BANK: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_READ && !acc_a && !idx_mode) |-> addr_q[7:0] == fld &&
    addr_q[11:8] == ((fld < ACC_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK))
    else $error("access bank address wrong");
  AST_BANKED: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_READ && acc_a) |-> addr_q == {bank_q, fld})
    else $error("banked address wrong");
  AST_INDEXED: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_READ && ext_en_q && !acc_a && fld <= IDX_LIMIT) |-> addr_q == idx_base_q + {4'h0, fld})
    else $error("indexed address wrong");
  AST_FOUR_PHASES: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_DECODE) |=> phase_q == PH_READ ##1 phase_q == PH_PROCESS ##1 phase_q == PH_WRITE ##1 phase_q == PH_IDLE)
    else $error("instruction cycle not four phases");
  AST_RL_KEEPS_CARRY: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_DECODE && is_rl) |-> ##4 carry_q == $past(carry_q, 4))
    else $error("left rotate touched carry");
  AST_ZERO_FLAG: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
    (phase_q == PH_WRITE && (is_rl || instr_q[15:10] == OPC_RRC)) |=>
    zero_q == ($past(res_q) == 8'h00) && neg_q == $past(res_q[7]))
    else $error("zero or negative flag wrong");
endmodule : rrx_rotate_exec

// ---- sim/rrx_testbench.sv ----
// Purpose: self-checking bench for the rotate execution block
// Assumes: zero wait state register bus, file bytes implemented at 0x000..0x3ff
// Notes: random cases use a fixed seed so that a failing run repeats
`timescale 1ns/100ps
module testbench;
  import rrx_pkg::*;
  logic mclk, rst, hsel, hwrite, hready, hresp, busy;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 32'h98552fb0;

  rrx_rotate_exec dut (.MCLK_IN(mclk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .BUSY_OUT(busy));

  // free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // bounded wait for the slave; a stuck slave ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge mclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        stop_test();
      end
      @(posedge mclk);
    end
  endtask : wait_ready

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask : rdc

  // effective file address from the access bit, bank and indexed mode
  function automatic logic [11:0] resolve(logic ext, logic a, logic [7:0] f, logic [3:0] bank, logic [11:0] ibase);
    if (a)
      return {bank, f};
    if (ext && f <= 8'h5f)
      return ibase + {4'h0, f};
    return (f < 8'h80) ? {4'h0, f} : {4'hf, f};
  endfunction : resolve

  task automatic run_case(input logic left, d, a, input logic [7:0] f, val, wv, input logic [3:0] bank,
      input logic ext, input logic [11:0] ibase, input logic [2:0] fl);
    logic [11:0] ea;
    logic [7:0] opnd, res;
    logic c;
    int n;
    ea = resolve(ext, a, f, bank, ibase);
    // the upper access bank has no storage, so the operand reads as zero
    opnd = (ea < 12'h400) ? val : 8'h00;
    res = left ? {opnd[6:0], opnd[7]} : {fl[0], opnd[7:1]};
    c = left ? fl[0] : opnd[0];
    wr(OFS_CTRL, {31'h0, ext});
    wr(OFS_BANK, {28'h0, bank});
    wr(OFS_IDX_BASE, {20'h0, ibase});
    wr(OFS_FADDR, {20'h0, ea});
    wr(OFS_FDATA, {24'h0, val});
    wr(OFS_WREG, {24'h0, wv});
    wr(OFS_STATUS, {29'h0, fl});
    wr(OFS_INSTR, {16'h0, left ? OPC_RLNC : OPC_RRC, d, a, f});
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (busy === 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
    check("busy cycles", n, 4);
    rdc("wreg", OFS_WREG, {24'h0, d ? wv : res});
    rdc("fdata", OFS_FDATA, {24'h0, (ea < 12'h400) ? (d ? res : val) : 8'h00});
    rdc("lastaddr", OFS_LASTADDR, {20'h0, ea});
    rdc("status", OFS_STATUS, {29'h0, res[7], res == 8'h00, c});
  endtask : run_case

  initial begin
    logic [7:0] offs [6];
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    offs = '{OFS_CTRL, OFS_WREG, OFS_STATUS, OFS_LASTADDR, OFS_FDATA, 8'h24};
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped offset reads zero
    foreach (offs[i])
      rdc("reset value", offs[i], 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    $display("test reset done");
    // worked examples and address corners
    run_case(1'b1, 1'b1, 1'b0, 8'h25, 8'hab, 8'h00, 4'h2, 1'b0, 12'h000, 3'b000);
    run_case(1'b0, 1'b0, 1'b0, 8'h30, 8'he6, 8'h11, 4'h1, 1'b0, 12'h000, 3'b000);
    run_case(1'b0, 1'b1, 1'b0, 8'h5f, 8'h81, 8'h00, 4'h3, 1'b1, 12'h100, 3'b001);
    run_case(1'b1, 1'b1, 1'b0, 8'h60, 8'h80, 8'h00, 4'h3, 1'b1, 12'h100, 3'b001);
    run_case(1'b1, 1'b0, 1'b1, 8'hff, 8'h00, 8'h77, 4'h3, 1'b1, 12'h200, 3'b110);
    run_case(1'b0, 1'b1, 1'b0, 8'h80, 8'h55, 8'h00, 4'h0, 1'b0, 12'h000, 3'b001);
    $display("test corners done");
    // random operations over banks, modes and flags
    repeat (24)
      run_case($random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
        4'($random(seed) & 3), $random(seed), 12'($random(seed) & 12'h2ff), $random(seed));
    $display("test random done");
    // undefined opcode sets the sticky flag; writes during the cycle are dropped
    wr(OFS_STATUS, 32'h0);
    wr(OFS_WREG, 32'h5a);
    wr(OFS_INSTR, 32'h0000ffff);
    wr(OFS_WREG, 32'ha5);
    repeat (6) @(posedge mclk);
    rdc("wreg while busy", OFS_WREG, 32'h5a);
    rdc("bad opcode", OFS_STATUS, 32'h200);
    wr(OFS_STATUS, 32'h200);
    rdc("bad opcode cleared", OFS_STATUS, 32'h0);
    rdc("bad opcode kept", OFS_INSTR, 32'h0000ffff);
    $display("test bad opcode done");
    // reset in mid-run must clear what the runs above left behind
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdc("wreg after reset", OFS_WREG, 32'h0);
    rdc("instr after reset", OFS_INSTR, 32'h0);
    rdc("bank after reset", OFS_BANK, 32'h0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : testbench
